// >>> hdl/qio_quad_out.sv
// angle to A/B/Z quadrature converter with hysteresis and config registers
module qio_quad_out
  import qio_pkg::*;
#(
  parameter int ANGLE_BITS = ANGLE_W,
  parameter int BUF_DEPTH = FIFO_DEPTH
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [ANGLE_BITS-1:0] angle_data,
  input wire logic angle_valid,
  output logic angle_ready,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  output logic quad_a,
  output logic quad_b,
  output logic quad_z
);

  // the scaling arithmetic assumes 4096 steps per turn
  if (ANGLE_BITS != ANGLE_W)
    $error("qio_quad_out: ANGLE_BITS must be 12");

  // the angle fifo wraps its pointers, so only powers of two work
  if (BUF_DEPTH < 2 || (1 << $clog2(BUF_DEPTH)) != BUF_DEPTH)
    $error("qio_quad_out: BUF_DEPTH must be a power of two >= 2");

  //////////////////////////////////////////////////////////////////////////
  // decoding functions

  // resolution code to interpolation factor; zero marks a code not served
  function automatic logic [FACTOR_W-1:0] factor_of(input logic [7:0] code);
    logic [FACTOR_W-1:0] f;
    f = '0;
    if (code <= RES_LIN_MAX)
      f = FACTOR_W'(code) + FACTOR_W'(1);
    else if (code == RES_256)
      f = FACTOR_256;
    else if (code == RES_512)
      f = FACTOR_512;
    else if (code == RES_1024)
      f = FACTOR_1024;
    return f;
  endfunction

  // hysteresis code to angle steps: 2, 4, 8, 16 of 4096
  function automatic logic [ANGLE_W-1:0] hys_of(input logic [1:0] code);
    return HYS_BASE << code;
  endfunction

  // map an angle (0..4095) onto the edge count of the present resolution
  function automatic logic [ANGLE_W-1:0] scale_of(
    input logic [ANGLE_W-1:0] ang,
    input logic [EDGE_W-1:0] edges
  );
    logic [ANGLE_W+EDGE_W-1:0] prod;
    prod = (ANGLE_W+EDGE_W)'(ang) * (ANGLE_W+EDGE_W)'(edges);
    return prod[2*ANGLE_W-1:ANGLE_W];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // angle buffer

  qio_stream_if #(.W(ANGLE_W)) in_s ();
  qio_stream_if #(.W(ANGLE_W)) out_s ();

  assign in_s.valid = angle_valid;
  assign in_s.data = angle_data;

  qio_fifo #(.W(ANGLE_W), .DEPTH(BUF_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .push(in_s),
    .pop(out_s)
  );

  // ready is the fifo's registered not-full flag
  assign angle_ready = in_s.ready;

  //////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic [7:0] res_q;
  logic [7:0] index_position_setting_q;
  logic [1:0] hys_q;
  logic [1:0] ab_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  wire wr_res = cfg_wr_en && (cfg_addr == ADDR_RES);
  wire wr_index_position_setting = cfg_wr_en && (cfg_addr == ADDR_INDEX_POSITION_SETTING);
  wire wr_hys_ab = cfg_wr_en && (cfg_addr == ADDR_HYS_AB);
  // an unserved resolution code is dropped, the old setting stays
  wire res_ok = (factor_of(cfg_wdata) != '0);
  // only a real change restarts the converter
  wire res_change = wr_res && res_ok && (cfg_wdata != res_q);

  // register writes
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      res_q <= RES_RST;
      index_position_setting_q <= INDEX_POSITION_SETTING_RST;
      hys_q <= HYS_RST;
      ab_q <= AB_RST;
    end
    else
    begin
      if (wr_res && res_ok)
        res_q <= cfg_wdata;
      if (wr_index_position_setting)
        index_position_setting_q <= cfg_wdata;
      if (wr_hys_ab)
      begin
        hys_q <= cfg_wdata[HYS_LSB+1:HYS_LSB];
        ab_q <= cfg_wdata[AB_LSB+1:AB_LSB];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // derived settings

  wire [FACTOR_W-1:0] factor = factor_of(res_q);
  wire [EDGE_W-1:0] edges = {factor, 2'b00};
  wire [EDGE_W-1:0] edges_half = {1'b0, edges[EDGE_W-1:1]};
  wire [ANGLE_W-1:0] hys = hys_of(hys_q);
  // index step of 1.4 degrees is 16 angle steps
  wire [ANGLE_W-1:0] zang = {index_position_setting_q, {INDEX_POSITION_SETTING_SHIFT{1'b0}}};
  wire [ANGLE_W-1:0] zraw = scale_of(zang, edges);
  // index sits on the quadrature state with A and B high
  // index uses only its own setting, no commutation zero
  wire [ANGLE_W-1:0] zidx = {zraw[ANGLE_W-1:2], 2'b00};

  //////////////////////////////////////////////////////////////////////////
  // tracked position with hysteresis

  qio_state_e state_q;
  qio_state_e state_d;
  logic [ANGLE_W-1:0] pos_q;
  logic [ANGLE_W-1:0] pos_d;
  logic [ANGLE_W-1:0] cnt_q;
  logic [ANGLE_W-1:0] cnt_d;

  wire [ANGLE_W-1:0] cand = out_s.data;
  wire [ANGLE_W-1:0] cand_hys = cand + hys;
  // modular signed distances; wrap through zero is handled for free
  wire [ANGLE_W-1:0] diff_up = cand - pos_q;
  wire [ANGLE_W-1:0] diff_dn = cand_hys - pos_q;
  wire move_up = !diff_up[ANGLE_W-1] && (diff_up != '0);
  wire move_dn = diff_dn[ANGLE_W-1];

  // target edge count and stepping toward it
  wire [ANGLE_W-1:0] tgt = scale_of(pos_q, edges);
  wire at_tgt = (cnt_q == tgt);
  wire [EDGE_W-1:0] fwd_dist = (tgt >= cnt_q) ?
    EDGE_W'(tgt) - EDGE_W'(cnt_q) :
    EDGE_W'(tgt) + edges - EDGE_W'(cnt_q);
  wire step_up = (fwd_dist <= edges_half);
  wire cnt_top = (EDGE_W'(cnt_q) == edges - EDGE_W'(1));
  wire [ANGLE_W-1:0] cnt_up = cnt_top ? '0 : cnt_q + ANGLE_W'(1);
  wire [ANGLE_W-1:0] cnt_dn = (cnt_q == '0) ?
    ANGLE_W'(edges - EDGE_W'(1)) : cnt_q - ANGLE_W'(1);

  // a sample is taken only once the previous one is fully stepped out,
  // so the fifo fills while the edge generator is busy
  wire take = out_s.valid && ((state_q == ST_INIT) ||
    ((state_q == ST_RUN) && at_tgt));
  assign out_s.ready = (state_q == ST_INIT) ||
    ((state_q == ST_RUN) && at_tgt);

  // next state, position and edge count
  always_comb
  begin
    state_d = state_q;
    pos_d = pos_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_INIT:
      begin
        if (take)
        begin
          pos_d = cand;
          state_d = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        // absolute position reloaded without emitting edges
        cnt_d = tgt;
        state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (take)
        begin
          // forward edges fall on the plain angle every time
          if (move_up)
            pos_d = cand;
          // backward only past the hysteresis, shifted by it
          else if (move_dn)
            pos_d = cand_hys;
        end
        // one step per clock keeps edges on the even grid
        else if (!at_tgt)
          cnt_d = step_up ? cnt_up : cnt_dn;
      end
      default:
        state_d = ST_INIT;
    endcase
    // a resolution change restarts the converter
    if (res_change)
      state_d = ST_INIT;
  end

  // converter state
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_INIT;
      pos_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      pos_q <= pos_d;
      cnt_q <= cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // quadrature outputs

  // count bits 00,01,10,11 give AB = 11,01,00,10; A leads going up
  wire raw_a = ~(cnt_q[1] ^ cnt_q[0]);
  wire raw_b = ~cnt_q[1];
  wire [1:0] raw_ab = {raw_a, raw_b};
  wire out_z = (cnt_q == zidx);
  wire run = (state_q == ST_RUN);

  // each lane keeps its last running level while the position reloads;
  // polarity is applied after the hold, so a polarity write reaches
  // the pins even before the first angle word arrives
  for (genvar i = 0; i < 2; i++)
  begin : g_lane
    logic held_q;
    logic pin_q;
    wire lvl = run ? raw_ab[i] : held_q;
    always_ff @(posedge clock or negedge nrst)
    begin
      if (!nrst)
      begin
        held_q <= 1'b1;
        pin_q <= 1'b1;
      end
      else
      begin
        held_q <= lvl;
        pin_q <= lvl ^ ab_q[i];
      end
    end
  end

  // lane 1 is A, lane 0 is B
  assign quad_a = g_lane[1].pin_q;
  assign quad_b = g_lane[0].pin_q;

  // index holds with the lanes while the position is being reloaded
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      quad_z <= 1'b1;
    else if (run)
      quad_z <= out_z;
  end

  //////////////////////////////////////////////////////////////////////////
  // register read back

  // read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_d = '0;
    case (cfg_addr)
      ADDR_RES:
        rdata_d = res_q;
      ADDR_INDEX_POSITION_SETTING:
        rdata_d = index_position_setting_q;
      ADDR_HYS_AB:
      begin
        rdata_d[HYS_LSB+1:HYS_LSB] = hys_q;
        rdata_d[AB_LSB+1:AB_LSB] = ab_q;
      end
      ADDR_POS_LO:
        rdata_d = cnt_q[7:0];
      ADDR_POS_HI:
        rdata_d = {state_q == ST_RUN, 3'b000, cnt_q[11:8]};
      default:
        rdata_d = '0;
    endcase
  end

  // read data held until the next read strobe
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= '0;
    else if (cfg_rd_en)
      rdata_q <= rdata_d;
  end

  assign cfg_rdata = rdata_q;
endmodule

// >>> hdl/qio_pkg.sv
// constants and types of the quadrature interpolator output block
package qio_pkg;
  // angle word and rotation
  localparam int ANGLE_W = 12;
  localparam int EDGE_W = 13;
  localparam int FACTOR_W = 11;
  // configuration addresses
  localparam logic [7:0] ADDR_RES = 8'h06;
  localparam logic [7:0] ADDR_INDEX_POSITION_SETTING = 8'h07;
  localparam logic [7:0] ADDR_HYS_AB = 8'h08;
  localparam logic [7:0] ADDR_POS_LO = 8'h20;
  localparam logic [7:0] ADDR_POS_HI = 8'h21;
  // field positions inside the shared hysteresis/polarity register
  localparam int HYS_LSB = 6;
  localparam int AB_LSB = 0;
  // values after reset
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [7:0] INDEX_POSITION_SETTING_RST = 8'h00;
  localparam logic [1:0] HYS_RST = 2'h0;
  localparam logic [1:0] AB_RST = 2'h0;
  // resolution codes
  localparam logic [7:0] RES_LIN_MAX = 8'h7F;
  localparam logic [7:0] RES_256 = 8'h80;
  localparam logic [7:0] RES_512 = 8'h81;
  localparam logic [7:0] RES_1024 = 8'h82;
  localparam logic [10:0] FACTOR_256 = 11'h100;
  localparam logic [10:0] FACTOR_512 = 11'h200;
  localparam logic [10:0] FACTOR_1024 = 11'h400;
  // hysteresis of code 0 in angle steps (0.17 deg of 4096 steps/turn)
  localparam logic [11:0] HYS_BASE = 12'h002;
  // index setting step in angle steps (1.4 deg = 16 of 4096)
  localparam int INDEX_POSITION_SETTING_SHIFT = 4;
  // fifo in the angle path
  localparam int FIFO_DEPTH = 16;
  // converter states, gray along init -> load -> run
  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN = 2'b11
  } qio_state_e;
endpackage

// >>> hdl/qio_stream_if.sv
// valid/ready word stream between the block's own modules
interface qio_stream_if #(parameter int W = 12);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> hdl/qio_fifo.sv
// synchronous fifo with registered room and empty flags
module qio_fifo
  import qio_pkg::*;
#(
  parameter int W = 12,
  parameter int DEPTH = 16
)
(
  input wire logic clock,
  input wire logic nrst,
  qio_stream_if.snk push,
  qio_stream_if.src pop
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two for the wrapping pointers
  if (DEPTH < 2 || (1 << AW) != DEPTH)
    $error("qio_fifo: DEPTH must be a power of two >= 2");

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  // room is kept as its own flop so ready leaves the block undecoded
  logic room_q;
  logic empty_q;
  wire do_push = push.valid && room_q;
  wire do_pop = pop.ready && !empty_q;
  wire [AW:0] cnt_d = cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);

  assign push.ready = room_q;
  assign pop.valid = !empty_q;
  assign pop.data = mem[rp_q];

  // storage has no reset; only pointers, count and flags need defined values
  always_ff @(posedge clock)
  begin
    if (do_push)
      mem[wp_q] <= push.data;
  end

  // pointers and flags, flags registered so ready comes from a flop
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      room_q <= 1'b1;
      empty_q <= 1'b1;
    end
    else
    begin
      wp_q <= wp_q + AW'(do_push);
      rp_q <= rp_q + AW'(do_pop);
      cnt_q <= cnt_d;
      room_q <= (cnt_d != (AW+1)'(DEPTH));
      empty_q <= (cnt_d == '0);
    end
  end
endmodule

// >>> bench/qio_quad_out_sva.sv
// assertion checker for the quadrature output block
module qio_quad_out_sva
  import qio_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic angle_ready,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic quad_z
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [7:0] res_q;
  logic [7:0] hab_q;
  // decode of the watched accesses
  wire logic wr_res = cfg_wr_en && cfg_addr == ADDR_RES;
  wire logic rd_res = cfg_rd_en && cfg_addr == ADDR_RES;
  wire logic rd_hab = cfg_rd_en && cfg_addr == ADDR_HYS_AB;
  wire logic res_ok = cfg_wdata <= RES_1024;
  wire logic [1:0] ab_w = hab_q[1:0];
  wire logic [1:0] hys_w = hab_q[7:6];
  //////////////////////////////////////////
  // shadow copy, invalid codes never land
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      res_q <= RES_RST;
      hab_q <= 8'h00;
    end
    else
    begin
      if (wr_res && res_ok)
        res_q <= cfg_wdata;
      if (cfg_wr_en && cfg_addr == ADDR_HYS_AB)
        hab_q <= cfg_wdata & 8'hC3;
    end
  end
  //////////////////////////////////////////
  // a polarity change may flip both lines, so it is excluded
  property p_one_edge;
    hab_q == $past(hab_q, 2) |-> !($changed(quad_a) && $changed(quad_b));
  endproperty
  a_one_edge: assert property (p_one_edge)
    else $error("both quadrature lines moved in one cycle");
  property p_res_read;
    rd_res |=> cfg_rdata == $past(res_q);
  endproperty
  a_res_read: assert property (p_res_read)
    else $error("resolution readback wrong");
  property p_res_refuse;
    wr_res && !res_ok ##2 rd_res |=> cfg_rdata == $past(res_q, 3);
  endproperty
  a_res_refuse: assert property (p_res_refuse)
    else $error("invalid resolution code was taken");
  property p_ab_read;
    rd_hab |=> cfg_rdata[1:0] == $past(ab_w) && cfg_rdata[5:2] == 4'h0;
  endproperty
  a_ab_read: assert property (p_ab_read)
    else $error("polarity readback wrong");
  property p_hys_read;
    rd_hab |=> cfg_rdata[7:6] == $past(hys_w);
  endproperty
  a_hys_read: assert property (p_hys_read)
    else $error("hysteresis readback wrong");
  property p_restart;
    wr_res && res_ok && cfg_wdata != res_q |=>
      ##1 $stable({quad_a, quad_b, quad_z})[*2];
  endproperty
  a_restart: assert property (p_restart)
    else $error("outputs moved during restart");
  property p_rst_level;
    $rose(nrst) |-> quad_a && quad_b && quad_z;
  endproperty
  a_rst_level: assert property (p_rst_level)
    else $error("outputs not high after reset");
  property p_z_ab;
    quad_z && hab_q == $past(hab_q, 3) |-> {quad_a, quad_b} == ~ab_w;
  endproperty
  a_z_ab: assert property (p_z_ab)
    else $error("A/B level at index wrong");
  c_full: cover property ($fell(angle_ready));
  c_index: cover property ($rose(quad_z));
  c_restart: cover property (wr_res && res_ok && cfg_wdata != res_q);
endmodule

// >>> bench/qio_edge_counter.sv
// external up/down counter following the A/B edges
module qio_edge_counter
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic quad_a,
  input wire logic quad_b,
  output logic signed [15:0] count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_q;
  // gray levels to phase; polarity must be zero while counting
  wire logic [1:0] ab = {quad_a, quad_b};
  wire logic [1:0] ph_d = ab == 2'b11 ? 2'h0 : ab == 2'b01 ? 2'h1 :
    ab == 2'b00 ? 2'h2 : 2'h3;
  wire logic [1:0] diff = ph_d - ph_q;
  // a jump of two phases is ambiguous and is not counted
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ph_q <= 2'h0;
      count <= '0;
    end
    else
    begin
      ph_q <= ph_d;
      if (diff == 2'h1)
        count <= count + 16'sd1;
      else if (diff == 2'h3)
        count <= count - 16'sd1;
    end
  end
endmodule

// >>> bench/tb.sv
// self-checking testbench of the quadrature output block
module tb
  import qio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, nrst = 0, angle_valid = 0, cfg_wr_en = 0, cfg_rd_en = 0;
  logic [11:0] angle_data = '0;
  logic [7:0] cfg_addr = '0, cfg_wdata = '0, cfg_rdata;
  logic angle_ready, quad_a, quad_b, quad_z;
  logic signed [15:0] count, c0, c1;
  int n_mismatch = 0, checks_done = 0;
  always #2.5 clock = ~clock;
  qio_quad_out DUT (.clock(clock), .nrst(nrst), .angle_data(angle_data),
    .angle_valid(angle_valid), .angle_ready(angle_ready),
    .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .quad_a(quad_a),
    .quad_b(quad_b), .quad_z(quad_z));
  qio_edge_counter cnt (.clock(clock), .nrst(nrst), .quad_a(quad_a),
    .quad_b(quad_b), .count(count));
  //////////////////////////////////////////
  // edges per turn: four per period of the factor
  function automatic logic [15:0] edges(input logic [7:0] c);
    return c <= RES_LIN_MAX ? 16'(4 * (c + 1)) : 16'(1024 << (c - 8'h80));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_wr_en = 1;
    cfg_addr = a;
    cfg_wdata = d;
    tick(1);
    cfg_wr_en = 0;
    // one idle edge, so back-to-back calls never retoggle the strobe
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cfg_rd_en = 1;
    cfg_addr = a;
    tick(1);
    cfg_rd_en = 0;
    check({8'h00, cfg_rdata}, {8'h00, exp});
    tick(1);
  endtask
  // valid stays up between words; settle drops it
  task automatic push(input logic [11:0] a);
    int i;
    angle_valid = 1;
    angle_data = a;
    for (i = 0; i < 5000 && !angle_ready; i++)
      tick(1);
    if (i == 5000)
    begin
      n_mismatch++;
      results();
    end
    tick(1);
  endtask
  // idle once the counter rests for 40 cycles
  task automatic settle();
    int i, q;
    angle_valid = 0;
    q = 0;
    for (i = 0; i < 20000 && q < 40; i++)
    begin
      c0 = count;
      tick(1);
      q = (count === c0) ? q + 1 : 0;
    end
    if (q < 40)
    begin
      n_mismatch++;
      results();
    end
  endtask
  //////////////////////////////////////////
  initial
  begin
    int k, h;
    int unsigned s;
    logic [7:0] codes [6];
    s = $urandom(32'h962E);
    codes = '{8'h01, 8'h7F, 8'h80, 8'h81, 8'(s % 127), 8'h82};
    tick(5);
    nrst = 1;
    rd(ADDR_RES, RES_RST);
    rd(ADDR_HYS_AB, 8'h00);
    rd(8'h30, 8'h00);
    // amplitude regulation enable lives outside this block
    wr(ADDR_INDEX_POSITION_SETTING, 8'h00);
    $display("reset test done");
    // each start and end sits at angle 0, so no reload jump
    foreach (codes[i])
    begin
      wr(ADDR_RES, codes[i]);
      rd(ADDR_RES, codes[i]);
      wr(ADDR_RES, 8'h83 + 8'($urandom % 125));
      rd(ADDR_RES, codes[i]);
      push(12'h000);
      settle();
      c1 = count;
      for (k = 1; k <= 16; k++)
        push(12'(k * 256));
      settle();
      check(16'(count - c1), edges(codes[i]));
    end
    $display("resolution test done");
    for (k = 0; k < 4; k++)
    begin
      wr(ADDR_HYS_AB, {k[1:0], 4'hF, k[1:0]});
      rd(ADDR_HYS_AB, {k[1:0], 4'h0, k[1:0]});
      tick(4);
      check({13'h0, quad_a, quad_b, quad_z}, {13'h0, ~k[1:0], 1'b1});
    end
    $display("polarity test done");
    for (h = 0; h < 4; h++)
    begin
      wr(ADDR_HYS_AB, {h[1:0], 6'h00});
      push(12'd1000);
      settle();
      c1 = count;
      push(12'(1001 - (2 << h)));
      settle();
      check(16'(count - c1), 16'h0000);
      push(12'(995 - (2 << h)));
      settle();
      check(16'(count - c1), 16'hFFFB);
      push(12'd1000);
      settle();
      check(16'(count - c1), 16'h0000);
    end
    $display("hysteresis test done");
    // index moved forward to 1008 steps; A and B must be high there
    wr(ADDR_INDEX_POSITION_SETTING, 8'h3F);
    rd(ADDR_INDEX_POSITION_SETTING, 8'h3F);
    push(12'd1008);
    settle();
    check({13'h0, quad_a, quad_b, quad_z}, 16'h0007);
    rd(ADDR_POS_LO, 8'hF0);
    rd(ADDR_POS_HI, 8'h83);
    $display("index test done");
    results();
  end
endmodule
bind qio_quad_out qio_quad_out_sva chk (.clock(clock), .nrst(nrst),
  .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
  .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .angle_ready(angle_ready),
  .quad_a(quad_a), .quad_b(quad_b), .quad_z(quad_z));
